// ### adcs_sequencer.sv
// conversion sequencer for a five-channel successive-approximation converter
`timescale 1ns/1ps

// Summary of operation
// - resolution bit zero gives twelve-bit conversions
// - time bits 101 select division 1/32
// - channel pattern 0100 routes input four
// - writing run bit one starts conversion
// - first twelve-bit conversion takes double time
// - later and eight-bit conversions take normal time
// - completion sets done, clears run together
// - done with enable raises vector 0043H request
// - done stays set until software writes zero
// - writing run zero aborts, result invalid
// - reset clears run and halts converter
// - time is (base/ratio + 2) thirds cycle
// - three time bits pick 1/1..1/128
// - eight-bit leaves low byte, twelve fills nibble
module adcs_sequencer (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // register writes
  input wire logic WR_CTRL,
  input wire logic WR_MODE,
  input wire logic WR_RLOW,
  input wire logic [7:0] WR_DATA,
  // register read values
  output logic [7:0] CTRL_RD,
  output logic [7:0] MODE_RD,
  output logic [7:0] RLOW_RD,
  output logic [7:0] RHIGH_RD,
  // analog front end
  input wire logic [11:0] AIN_CODE,
  output logic [4:0] ANALOG_SEL,
  output logic LADDER_EN,
  // interrupt
  output logic IRQ,
  output logic [15:0] IRQ_VECTOR
);

  // ==========================================================
  // reset synchroniser
  // assertion acts at once, release waits two edges so no flop sees a runt
  logic rst_meta_r;  // first stage, read only by second
  logic rst_n;       // released copy used everywhere
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ==========================================================
  // state and registers
  // every register below holds still while the clock enable is low
  adcs_pkg::adcs_state_t state_r;  // idle or converting
  adcs_pkg::adcs_ctrl_t ctrl_r;    // control register (run kept in state)
  logic [7:0] mode_r;              // mode control register
  adcs_pkg::adcs_result_t res_r;   // result registers
  logic first_r;                   // next twelve-bit conversion is doubled
  logic [14:0] acc_r;              // elapsed time, scaled thirds
  logic [14:0] target;             // time needed for this conversion
  logic [2:0] tm;                  // time division code
  logic res8;                      // eight-bit mode selected
  logic run;                       // conversion in progress
  logic start;                     // software start this cycle
  logic abort;                     // software stop this cycle
  logic complete;                  // conversion ends this cycle

  assign run = (state_r == adcs_pkg::ST_CONV);
  assign res8 = mode_r[adcs_pkg::MODE_RES_BIT];
  assign tm = {res_r.low[adcs_pkg::RLOW_TM2_BIT], mode_r[adcs_pkg::MODE_TM1_BIT],
               mode_r[adcs_pkg::MODE_TM0_BIT]};

  // ==========================================================
  // start, abort and completion decode
  // run bit written one while idle
  // a run write while already converting is ignored, never a restart
  assign start = CE && WR_CTRL && WR_DATA[adcs_pkg::CTRL_RUN_BIT] && !run;
  // run bit written zero stops a conversion
  assign abort = CE && WR_CTRL && !WR_DATA[adcs_pkg::CTRL_RUN_BIT] && run;
  // abort beats completion so a stopped conversion never posts data
  // comparing the next accumulator value ends the count on the last needed cycle
  assign complete = CE && run && !abort && (acc_r + adcs_pkg::ACC_STEP >= target);

  // ==========================================================
  // conversion time target
  always_comb begin
    logic [14:0] base;
    base = adcs_pkg::BASE_12;
    // resolution bit zero picks the twelve-bit base
    if (res8) begin
      base = adcs_pkg::BASE_8;
    end
    // base over ratio plus two, counted in thirds of a cycle
    // ratio is 1/2**tm, so base over ratio is base shifted by tm
    // code 101 gives base*32, i.e. division 1/32
    // a slower converter clock stretches only the base part; the two
    // thirds of setup stay fixed whatever the division
    target = 15'((base << tm) + adcs_pkg::OFFS_THIRDS);
    // first twelve-bit conversion runs twice as long
    if (first_r && !res8) begin
      target = 15'(target << 1);
    end
  end

  // ==========================================================
  // sequencer state; reset here halts any conversion
  // clock enable low freezes the state, timing included
  // reset returns to idle, run reads zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= adcs_pkg::ST_IDLE;
    end else if (CE) begin
      case (state_r)
        adcs_pkg::ST_IDLE: begin
          if (start) begin
            state_r <= adcs_pkg::ST_CONV;
          end
        end
        adcs_pkg::ST_CONV: begin
          // run drops on the edge that ends the completion cycle
          if (abort || complete) begin
            state_r <= adcs_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= adcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // elapsed time accumulator, restarts with each conversion
  // counts thirds of a cycle, three per clock; worst case stays below 2**14
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 15'h0000;
    end else if (CE) begin
      if (run && !complete && !abort) begin
        acc_r <= 15'(acc_r + adcs_pkg::ACC_STEP);
      end else begin
        acc_r <= 15'h0000;
      end
    end
  end

  // ==========================================================
  // control register fields other than run
  // run lives in the state register, so it never disagrees with the sequencer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= adcs_pkg::CTRL_RST;
    end else if (CE) begin
      if (WR_CTRL) begin
        ctrl_r.chsel <= WR_DATA[adcs_pkg::CTRL_CHSEL_MSB:adcs_pkg::CTRL_CHSEL_LSB];
        ctrl_r.ie <= WR_DATA[adcs_pkg::CTRL_IE_BIT];
      end
      // done holds until written zero; a completion wins
      if (complete) begin
        ctrl_r.done <= 1'b1;
      end else if (WR_CTRL) begin
        ctrl_r.done <= WR_DATA[adcs_pkg::CTRL_DONE_BIT];
      end
    end
  end

  // ==========================================================
  // mode register; fixed bits always store zero
  // only the resolution and two time bits are kept; the rest read zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= adcs_pkg::MODE_RST;
    end else if (CE && WR_MODE) begin
      mode_r <= 8'h00;
      mode_r[adcs_pkg::MODE_RES_BIT] <= WR_DATA[adcs_pkg::MODE_RES_BIT];
      mode_r[adcs_pkg::MODE_TM1_BIT] <= WR_DATA[adcs_pkg::MODE_TM1_BIT];
      mode_r[adcs_pkg::MODE_TM0_BIT] <= WR_DATA[adcs_pkg::MODE_TM0_BIT];
    end
  end

  // ==========================================================
  // doubling flag: armed by reset and by an 8-bit to 12-bit switch
  // aborted and eight-bit conversions leave the flag armed
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      first_r <= 1'b1;
    end else if (CE) begin
      // switch from eight to twelve bits re-arms doubling
      if (WR_MODE && res8 && !WR_DATA[adcs_pkg::MODE_RES_BIT]) begin
        first_r <= 1'b1;
      // once a twelve-bit conversion finished, normal time
      end else if (complete && !res8) begin
        first_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // result registers and the third time division bit
  // a twelve-bit completion in the same cycle as a low-byte write wins for the nibble
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      res_r.high <= adcs_pkg::RHIGH_RST;
      res_r.low <= adcs_pkg::RLOW_RST;
    end else if (CE) begin
      if (WR_RLOW) begin
        res_r.low[7:adcs_pkg::RLOW_DATA_LSB] <= WR_DATA[7:adcs_pkg::RLOW_DATA_LSB];
        res_r.low[adcs_pkg::RLOW_TM2_BIT] <= WR_DATA[adcs_pkg::RLOW_TM2_BIT];
      end
      // high byte always; low nibble only in twelve-bit mode
      if (complete) begin
        res_r.high <= AIN_CODE[11:4];
        if (!res8) begin
          res_r.low[7:adcs_pkg::RLOW_DATA_LSB] <= AIN_CODE[3:0];
        end
      end
    end
  end

  // ==========================================================
  // channel multiplexer select, one bit per input
  // codes five to fifteen select nothing, so a bad code drives no input
  // pattern 0100 drives the select of input four
  genvar ch;
  generate
    for (ch = 0; ch < adcs_pkg::NUM_CH; ch++) begin : g_sel
      assign ANALOG_SEL[ch] = run && (ctrl_r.chsel == 4'(ch));
    end
  endgenerate

  // ==========================================================
  // read back and outputs
  // run comes from the state, so software sees it drop together with done
  always_comb begin
    CTRL_RD = ctrl_r;
    CTRL_RD[adcs_pkg::CTRL_RUN_BIT] = run;
  end
  assign MODE_RD = mode_r;
  assign RLOW_RD = res_r.low;
  assign RHIGH_RD = res_r.high;
  // reference ladder only runs during a conversion
  assign LADDER_EN = run;
  // request while done and enable are both set
  assign IRQ = ctrl_r.done && ctrl_r.ie;
  assign IRQ_VECTOR = adcs_pkg::DONE_IRQ_VECTOR;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  // independent cycle count, wide enough for the longest doubled conversion
  logic [12:0] cyc_r;  // cycles spent in the current conversion
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 13'h0000;
    end else if (CE) begin
      cyc_r <= (run && !complete && !abort) ? 13'(cyc_r + 13'h0001) : 13'h0000;
    end
  end

  a_start_run: assert property (start |=> run && LADDER_EN)
    else $error("start did not raise run");
  a_done_run: assert property (complete |=> !run && ctrl_r.done)
    else $error("completion did not set done and clear run");
  a_done_sticky: assert property (ctrl_r.done && !WR_CTRL |=> ctrl_r.done)
    else $error("done flag dropped without a write");
  a_irq_raise: assert property (complete && ctrl_r.ie && !WR_CTRL |=> IRQ)
    else $error("no request on done with enable");
  a_abort_stop: assert property (abort && !WR_DATA[adcs_pkg::CTRL_DONE_BIT] |=>
      !run && !$rose(ctrl_r.done) && $stable(res_r.high))
    else $error("abort did not stop conversion");
  a_time_exact: assert property (complete |->
      (13'(cyc_r + 13'h0001) * 15'(adcs_pkg::ACC_STEP) >= target) &&
      (cyc_r * 15'(adcs_pkg::ACC_STEP) < target))
    else $error("conversion length wrong");
  a_div32_12b: assert property (tm == adcs_pkg::TM_DIV32 && !res8 && !first_r |->
      target == 15'h0682)
    else $error("1/32 twelve-bit time wrong");
  a_double_once: assert property (complete && !res8 |=> !first_r)
    else $error("doubling not cleared");
  a_dbl_first: assert property (first_r && !res8 |-> target[0] == 1'b0 && target >= 15'h006c)
    else $error("first twelve-bit time not doubled");
  a_sel_four: assert property (run && ctrl_r.chsel == 4'h4 |-> ANALOG_SEL == 5'h10)
    else $error("input four not selected");
  a_low_keep: assert property (complete && res8 && !WR_RLOW |=> $stable(res_r.low))
    else $error("low byte changed in 8-bit mode");

  // covers: each main scenario must be reached at least once
  c_conv_12: cover property (start ##[1:1000] complete && !res8);
  c_conv_8: cover property (start ##[1:1000] complete && res8);
  c_abort: cover property (start ##[1:20] abort);
  c_irq: cover property ($rose(IRQ));

endmodule

// ### adcs_pkg.sv
// constants and carrier types for the converter sequencer
package adcs_pkg;

  // ==========================================================
  // control register field positions
  localparam int CTRL_CHSEL_MSB = 7;  // channel select high bit
  localparam int CTRL_CHSEL_LSB = 4;  // channel select low bit
  localparam int CTRL_RUN_BIT = 2;    // conversion_run
  localparam int CTRL_DONE_BIT = 1;   // conversion_done_flag
  localparam int CTRL_IE_BIT = 0;     // done_irq_enable

  // ==========================================================
  // mode register and result low register field positions
  localparam int MODE_RES_BIT = 6;    // resolution_select, 1 = 8-bit
  localparam int MODE_TM1_BIT = 1;    // time_div_bit1
  localparam int MODE_TM0_BIT = 0;    // time_div_bit0
  localparam int RLOW_TM2_BIT = 0;    // time_div_bit2
  localparam int RLOW_DATA_LSB = 4;   // low result nibble starts here

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] RLOW_RST = 8'h00;
  localparam logic [7:0] RHIGH_RST = 8'h00;

  // ==========================================================
  // channels and interrupt vector
  localparam int NUM_CH = 5;
  localparam logic [3:0] CH_FOUR = 4'h4;            // analog_input_four
  localparam logic [15:0] DONE_IRQ_VECTOR = 16'h0043;

  // ==========================================================
  // conversion timing, all in thirds of a cycle:
  // time = (base / ratio + 2) * Tcyc / 3, ratio = 1 / 2**tm, tm = 0..7
  localparam int TM_MAX = 7;                         // ratio 1/128
  localparam logic [14:0] BASE_12 = 15'h0034;        // 52
  localparam logic [14:0] BASE_8 = 15'h0020;         // 32
  localparam logic [14:0] OFFS_THIRDS = 15'h0002;    // the "+ 2"
  localparam int THIRDS_PER_CYC = 3;                 // Tcyc / (1/3 Tcyc)
  localparam logic [14:0] ACC_STEP = 15'(THIRDS_PER_CYC);  // thirds per clock
  localparam logic [2:0] TM_DIV32 = 3'h5;            // 1/32

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic [3:0] chsel;  // channel select b3..b0
    logic fixed0;       // always zero
    logic run;          // conversion in progress
    logic done;         // sticky completion flag
    logic ie;           // done interrupt enable
  } adcs_ctrl_t;

  typedef struct packed {
    logic [7:0] high;   // result_high_reg
    logic [7:0] low;    // result_low_reg
  } adcs_result_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcs_state_t;

endpackage

// ### testbench.sv
// self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // design connections
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic CE = 1'b1;
  logic WR_CTRL = 1'b0;
  logic WR_MODE = 1'b0;
  logic WR_RLOW = 1'b0;
  logic [7:0] WR_DATA = 8'h00;
  logic [11:0] AIN_CODE = 12'habc;
  logic [7:0] CTRL_RD, MODE_RD, RLOW_RD, RHIGH_RD;
  logic [4:0] ANALOG_SEL;
  logic LADDER_EN, IRQ;
  logic [15:0] IRQ_VECTOR;
  int errors = 0;
  int checks = 0;
  adcs_sequencer dut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .WR_CTRL(WR_CTRL),
    .WR_MODE(WR_MODE), .WR_RLOW(WR_RLOW), .WR_DATA(WR_DATA), .CTRL_RD(CTRL_RD),
    .MODE_RD(MODE_RD), .RLOW_RD(RLOW_RD), .RHIGH_RD(RHIGH_RD), .AIN_CODE(AIN_CODE),
    .ANALOG_SEL(ANALOG_SEL), .LADDER_EN(LADDER_EN), .IRQ(IRQ), .IRQ_VECTOR(IRQ_VECTOR));
  // 125 MHz system clock
  initial begin
    forever #4 CLK = ~CLK;
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // expected busy cycles: ceil(T/3), T in thirds of a cycle, ratio 1/2**tm
  function automatic int exp_n(input bit res8, input int tm, input bit dbl);
    int t;
    t = int'(res8 ? adcs_pkg::BASE_8 : adcs_pkg::BASE_12) << tm;
    t = t + int'(adcs_pkg::OFFS_THIRDS);
    if (dbl && !res8) begin
      t = t * 2;
    end
    return (t + adcs_pkg::THIRDS_PER_CYC - 1) / adcs_pkg::THIRDS_PER_CYC;
  endfunction
  // one register write: 0 control, 1 mode, 2 result low
  task automatic wr(input int w, input logic [7:0] d);
    @(posedge CLK);
    WR_CTRL <= (w == 0);
    WR_MODE <= (w == 1);
    WR_RLOW <= (w == 2);
    WR_DATA <= d;
    @(posedge CLK);
    WR_CTRL <= 1'b0;
    WR_MODE <= 1'b0;
    WR_RLOW <= 1'b0;
  endtask
  // start a conversion and count the cycles that run stays high
  task automatic conv(input logic [7:0] cb, input int n);
    int cnt;
    cnt = 0;
    wr(0, cb);
    #1;
    check(ANALOG_SEL, (cb[7:4] < 4'h5) ? 16'(1 << cb[7:4]) : 16'h0);
    check(LADDER_EN, 16'h1);
    // poll the done flag until it reads one
    while (CTRL_RD[adcs_pkg::CTRL_DONE_BIT] !== 1'b1) begin
      cnt++;
      if (cnt > 5000) begin
        errors++;
        wrap_up();
      end
      @(posedge CLK);
      #1;
    end
    check(16'(cnt), 16'(n));
    check(CTRL_RD[2:1], 16'h1);
    check(LADDER_EN, 16'h0);
  endtask
  task automatic rst();
    ARST_N <= 1'b0;
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
  endtask
  // global watchdog against a hang
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    @(posedge CLK);
    rst();
    #1;
    check({CTRL_RD, MODE_RD}, 16'h0000);
    check({RLOW_RD, RHIGH_RD}, 16'h0000);
    check(IRQ_VECTOR, adcs_pkg::DONE_IRQ_VECTOR);
    // writes with clock enable low are ignored
    @(posedge CLK);
    CE <= 1'b0;
    wr(1, 8'h41);
    CE <= 1'b1;
    #1;
    check(MODE_RD, 16'h00);
    // twelve-bit, division 1/32, input four, first run doubled
    wr(1, 8'h01);
    wr(2, 8'h01);
    conv(8'h44, exp_n(0, 5, 1));
    check(CTRL_RD, 16'h42);
    check({RHIGH_RD, RLOW_RD}, 16'habc1);
    check(IRQ, 16'h0);
    repeat (5) @(posedge CLK);
    #1;
    check(CTRL_RD[1], 16'h1);
    // second twelve-bit run is normal and interrupts when enabled
    conv(8'h45, exp_n(0, 5, 0));
    check(IRQ, 16'h1);
    wr(0, 8'h41);
    #1;
    check({CTRL_RD, 7'h0, IRQ}, 16'h4100);
    // every division ratio and channel codes zero to seven
    // repeated samples, as an averaging routine takes them
    for (int tm = 0; tm < 8; tm++) begin
      wr(2, {7'h0, tm[2]});
      wr(1, {6'h0, tm[1:0]});
      conv({tm[3:0], 4'h4}, exp_n(0, tm, 0));
    end
    // eight-bit run keeps the low byte, then switch back doubles
    wr(2, 8'h91);
    wr(1, 8'h41);
    AIN_CODE <= 12'h5a3;
    conv(8'h44, exp_n(1, 5, 0));
    check({RHIGH_RD, RLOW_RD}, 16'h5a91);
    wr(1, 8'h01);
    conv(8'h44, exp_n(0, 5, 1));
    check(RLOW_RD, 16'h31);
    conv(8'h44, exp_n(0, 5, 0));
    // abort by writing run zero
    wr(1, 8'h00);
    wr(2, 8'h00);
    AIN_CODE <= 12'hfff;
    wr(0, 8'h44);
    repeat (3) @(posedge CLK);
    wr(0, 8'h40);
    #1;
    check({CTRL_RD, RHIGH_RD}, 16'h405a);
    check(LADDER_EN, 16'h0);
    // reset in mid-conversion halts and re-arms doubling
    wr(0, 8'h44);
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b0;
    #1;
    check({CTRL_RD, 3'h0, ANALOG_SEL}, 16'h0000);
    check(LADDER_EN, 16'h0);
    rst();
    conv(8'h44, exp_n(0, 0, 1));
    // run reads zero after completion, with no further write
    check(CTRL_RD[adcs_pkg::CTRL_RUN_BIT], 16'h0);
    wrap_up();
  end
endmodule
